// >>> core/ssx_alu.sv
// execution unit: subtract, swap, xor, rotate and sleep instructions
// Function
// - file minus accumulator, updates carry, digit carry, zero
// - destination bit picks accumulator or file
// - literal minus accumulator into accumulator, flags
// - sleep clears powerdown, sets timeout flag
// - sleep clears watchdog count and prescaler
// - after sleep, halt instruction oscillator
// - swap nibbles, status flags untouched
// - swap with destination one writes file
// - literal xor into accumulator, zero only
// - file xor with accumulator, zero only
// - file xor destination one writes file
// - rotate right through carry
module ssx_alu (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // instruction from decoder
  input wire logic EXEC_I,
  input wire ssx_pkg::ssx_op_t OP_I,
  input wire logic DEST_I,
  input wire logic [6:0] FILE_ADDR_I,
  input wire logic [7:0] LITERAL_I,
  // file register read data
  input wire logic [7:0] FILE_DATA_I,
  // wake event ends sleep
  input wire logic WAKE_I,
  // file register write port
  output logic FILE_WE_O,
  output logic [6:0] FILE_WADDR_O,
  output logic [7:0] FILE_WDATA_O,
  // architectural state
  output logic [7:0] ACC_O,
  output logic CARRY_O,
  output logic DIGIT_CARRY_FLAG_O,
  output logic ZERO_O,
  output logic TIMEOUT_FLAG_O,
  output logic POWERDOWN_FLAG_O,
  // watchdog clear and power state
  output logic WDT_CLR_O,
  output logic OSC_RUN_O,
  output logic SLEEPING_O
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ssx_pkg::ssx_state_t st;
    logic [7:0] acc;
    logic carry;
    logic dcarry;
    logic zero;
    logic timeout;
    logic powerdown;
    logic file_we;
    logic [6:0] file_waddr;
    logic [7:0] file_wdata;
    logic wdt_clr;
  } ssx_alu_state_t;

  ssx_alu_state_t s_r;
  ssx_alu_state_t s_nxt;
  logic [7:0] res;
  logic c_new;
  logic dc_new;
  logic upd_c;
  logic upd_dc;
  logic upd_z;
  logic writes;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  ssx_flag_calc u_calc (
    .op_i(OP_I),
    .acc_i(s_r.acc),
    .file_i(FILE_DATA_I),
    .lit_i(LITERAL_I),
    .carry_i(s_r.carry),
    .res_o(res),
    .carry_o(c_new),
    .dcarry_o(dc_new),
    .upd_c_o(upd_c),
    .upd_dc_o(upd_dc),
    .upd_z_o(upd_z),
    .writes_o(writes)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // instructions are ignored while asleep: the sleep state only waits for WAKE_I
  always_comb begin
    s_nxt = s_r;
    s_nxt.file_we = 1'h0;
    s_nxt.wdt_clr = 1'h0;
    case (s_r.st)
      ssx_pkg::SSX_ST_RUN: begin
        if (EXEC_I && OP_I == ssx_pkg::SSX_OP_SLEEP) begin
          s_nxt.powerdown = 1'h0;
          s_nxt.timeout = 1'h1;
          s_nxt.wdt_clr = 1'h1;
          s_nxt.st = ssx_pkg::SSX_ST_SLEEP;
        end else if (EXEC_I && writes) begin
          // literal forms always target the accumulator
          if (DEST_I == ssx_pkg::SSX_DEST_FILE && OP_I != ssx_pkg::SSX_OP_SUB_ACC_FROM_LITERAL
              && OP_I != ssx_pkg::SSX_OP_XOR_LITERAL_ACC) begin
            s_nxt.file_we = 1'h1;
            s_nxt.file_waddr = FILE_ADDR_I;
            s_nxt.file_wdata = res;
          end else begin
            s_nxt.acc = res;
          end
          if (upd_c) begin
            s_nxt.carry = c_new;
          end
          if (upd_dc) begin
            s_nxt.dcarry = dc_new;
          end
          if (upd_z) begin
            s_nxt.zero = (res == ssx_pkg::SSX_ZERO_BYTE);
          end
        end
      end
      ssx_pkg::SSX_ST_SLEEP: begin
        if (WAKE_I) begin
          s_nxt.st = ssx_pkg::SSX_ST_RUN;
        end
      end
      default: begin
        s_nxt.st = ssx_pkg::SSX_ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_r.st <= ssx_pkg::SSX_ST_RUN;
      s_r.acc <= ssx_pkg::SSX_ACC_RST;
      s_r.carry <= ssx_pkg::SSX_FLAG_RST;
      s_r.dcarry <= ssx_pkg::SSX_FLAG_RST;
      s_r.zero <= ssx_pkg::SSX_FLAG_RST;
      s_r.timeout <= ssx_pkg::SSX_TIMEOUT_RST;
      s_r.powerdown <= ssx_pkg::SSX_POWERDOWN_RST;
      s_r.file_we <= 1'h0;
      s_r.file_waddr <= 7'h00;
      s_r.file_wdata <= 8'h00;
      s_r.wdt_clr <= 1'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign FILE_WE_O = s_r.file_we;
  assign FILE_WADDR_O = s_r.file_waddr;
  assign FILE_WDATA_O = s_r.file_wdata;
  assign ACC_O = s_r.acc;
  assign CARRY_O = s_r.carry;
  assign DIGIT_CARRY_FLAG_O = s_r.dcarry;
  assign ZERO_O = s_r.zero;
  assign TIMEOUT_FLAG_O = s_r.timeout;
  assign POWERDOWN_FLAG_O = s_r.powerdown;
  assign WDT_CLR_O = s_r.wdt_clr;
  assign OSC_RUN_O = (s_r.st == ssx_pkg::SSX_ST_RUN);
  assign SLEEPING_O = (s_r.st == ssx_pkg::SSX_ST_SLEEP);
endmodule : ssx_alu

// >>> core/ssx_flag_calc.sv
// combinational result and flag generator for the execution block
module ssx_flag_calc (
  // operands
  input wire ssx_pkg::ssx_op_t op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] file_i,
  input wire logic [7:0] lit_i,
  input wire logic carry_i,
  // results
  output logic [7:0] res_o,
  output logic carry_o,
  output logic dcarry_o,
  output logic upd_c_o,
  output logic upd_dc_o,
  output logic upd_z_o,
  output logic writes_o
);
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] minu;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  // subtract done as minuend + ~acc + 1 so carry is the not-borrow
  always_comb begin
    minu = (op_i == ssx_pkg::SSX_OP_SUB_ACC_FROM_LITERAL) ? lit_i : file_i;
    diff = {1'h0, minu} + {1'h0, ~acc_i} + 9'h001;
    ndiff = {1'h0, minu[3:0]} + {1'h0, ~acc_i[3:0]} + 5'h01;
    res_o = ssx_pkg::SSX_ZERO_BYTE;
    carry_o = carry_i;
    dcarry_o = 1'h0;
    upd_c_o = 1'h0;
    upd_dc_o = 1'h0;
    upd_z_o = 1'h0;
    writes_o = 1'h1;
    case (op_i)
      ssx_pkg::SSX_OP_SUB_ACC_FROM_FILE, ssx_pkg::SSX_OP_SUB_ACC_FROM_LITERAL: begin
        res_o = diff[7:0];
        carry_o = diff[8];
        dcarry_o = ndiff[4];
        upd_c_o = 1'h1;
        upd_dc_o = 1'h1;
        upd_z_o = 1'h1;
      end
      ssx_pkg::SSX_OP_NIBBLE_SWAP_FILE: begin
        res_o = {file_i[ssx_pkg::SSX_NIB_LO:0], file_i[ssx_pkg::SSX_NIB_HI:4]};
      end
      ssx_pkg::SSX_OP_XOR_LITERAL_ACC: begin
        res_o = acc_i ^ lit_i;
        upd_z_o = 1'h1;
      end
      ssx_pkg::SSX_OP_XOR_ACC_FILE: begin
        res_o = acc_i ^ file_i;
        upd_z_o = 1'h1;
      end
      ssx_pkg::SSX_OP_ROTATE_RIGHT_CARRY: begin
        res_o = {carry_i, file_i[7:1]};
        carry_o = file_i[0];
        upd_c_o = 1'h1;
      end
      default: begin
        writes_o = 1'h0;
      end
    endcase
  end
endmodule : ssx_flag_calc

// >>> pkg/ssx_pkg.sv
// constants and types shared by the sub/swap/xor/sleep execution block
package ssx_pkg;
  // ----------------------------------------------------------------
  // operation codes presented by the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSX_OP_NONE = 3'h0,
    SSX_OP_SUB_ACC_FROM_FILE = 3'h1,
    SSX_OP_SUB_ACC_FROM_LITERAL = 3'h2,
    SSX_OP_NIBBLE_SWAP_FILE = 3'h3,
    SSX_OP_XOR_LITERAL_ACC = 3'h4,
    SSX_OP_XOR_ACC_FILE = 3'h5,
    SSX_OP_ROTATE_RIGHT_CARRY = 3'h6,
    SSX_OP_SLEEP = 3'h7
  } ssx_op_t;

  // ----------------------------------------------------------------
  // power state, gray coded along run -> sleep
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SSX_ST_RUN = 1'h0,
    SSX_ST_SLEEP = 1'h1
  } ssx_state_t;

  // ----------------------------------------------------------------
  // widths, field positions and reset values
  // ----------------------------------------------------------------
  localparam int SSX_DATA_W = 8;
  localparam int SSX_ADDR_W = 7;
  localparam int SSX_NIB_LO = 3;
  localparam int SSX_NIB_HI = 7;
  localparam logic SSX_DEST_ACC = 1'h0;
  localparam logic SSX_DEST_FILE = 1'h1;
  localparam logic [7:0] SSX_ACC_RST = 8'h00;
  localparam logic SSX_FLAG_RST = 1'h0;
  localparam logic SSX_TIMEOUT_RST = 1'h1;
  localparam logic SSX_POWERDOWN_RST = 1'h1;
  localparam logic [7:0] SSX_WDT_RST = 8'h00;
  localparam logic [7:0] SSX_PRESC_RST = 8'h00;
  localparam logic [7:0] SSX_ZERO_BYTE = 8'h00;
endpackage : ssx_pkg

// >>> tb/ssx_alu_asserts.sv
// port checker for the execution block
module ssx_alu_asserts (
  // clock, reset, instruction
  input wire logic REF_CLK_I, RST_N_I, EXEC_I, DEST_I,
  input wire ssx_pkg::ssx_op_t OP_I,
  input wire logic [7:0] LITERAL_I, FILE_DATA_I, FILE_WDATA_O, ACC_O,
  // flags and power state
  input wire logic FILE_WE_O, CARRY_O, DIGIT_CARRY_FLAG_O, ZERO_O,
  input wire logic TIMEOUT_FLAG_O, POWERDOWN_FLAG_O, WDT_CLR_O, OSC_RUN_O, SLEEPING_O
);
  logic [7:0] a_r, f_r, k_r;
  logic c_r;
  wire logic go = EXEC_I && !SLEEPING_O;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // operands held from the launching edge
  always_ff @(posedge REF_CLK_I) begin
    a_r <= ACC_O;
    f_r <= FILE_DATA_I;
    k_r <= LITERAL_I;
    c_r <= CARRY_O;
  end
  property p_sub_lit;
    go && OP_I == ssx_pkg::SSX_OP_SUB_ACC_FROM_LITERAL |=> ACC_O == k_r - a_r && CARRY_O == (a_r <= k_r)
      && DIGIT_CARRY_FLAG_O == (a_r[3:0] <= k_r[3:0]);
  endproperty
  a_sub_lit: assert property (p_sub_lit) else $error("literal subtract wrong");
  property p_sub_file;
    go && DEST_I && OP_I == ssx_pkg::SSX_OP_SUB_ACC_FROM_FILE |=> FILE_WE_O && FILE_WDATA_O == f_r - a_r
      && $stable(ACC_O) && CARRY_O == (a_r <= f_r);
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("file subtract wrong");
  property p_swap;
    go && DEST_I && OP_I == ssx_pkg::SSX_OP_NIBBLE_SWAP_FILE |=> FILE_WE_O
      && FILE_WDATA_O == {f_r[3:0], f_r[7:4]} && $stable(CARRY_O) && $stable(ZERO_O);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_xor_lit;
    go && OP_I == ssx_pkg::SSX_OP_XOR_LITERAL_ACC |=> ACC_O == (a_r ^ k_r) && ZERO_O == (ACC_O == 8'h00)
      && $stable(CARRY_O);
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("literal xor wrong");
  property p_xor_file;
    go && DEST_I && OP_I == ssx_pkg::SSX_OP_XOR_ACC_FILE |=> FILE_WDATA_O == (a_r ^ f_r) && $stable(ACC_O)
      && $stable(DIGIT_CARRY_FLAG_O);
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("file xor wrong");
  property p_rot;
    go && !DEST_I && OP_I == ssx_pkg::SSX_OP_ROTATE_RIGHT_CARRY |=> ACC_O == {c_r, f_r[7:1]} && CARRY_O == f_r[0];
  endproperty
  a_rot: assert property (p_rot) else $error("rotate wrong");
  property p_sleep;
    go && OP_I == ssx_pkg::SSX_OP_SLEEP |=> WDT_CLR_O && !POWERDOWN_FLAG_O && TIMEOUT_FLAG_O ##1 !WDT_CLR_O;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_osc;
    SLEEPING_O |-> !OSC_RUN_O;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator runs in sleep");
endmodule : ssx_alu_asserts
bind ssx_alu ssx_alu_asserts u_chk (.REF_CLK_I, .RST_N_I, .EXEC_I, .DEST_I, .OP_I, .LITERAL_I, .FILE_DATA_I,
  .FILE_WDATA_O, .ACC_O, .FILE_WE_O, .CARRY_O, .DIGIT_CARRY_FLAG_O, .ZERO_O, .TIMEOUT_FLAG_O,
  .POWERDOWN_FLAG_O, .WDT_CLR_O, .OSC_RUN_O, .SLEEPING_O);

// >>> tb/ssx_alu_tb.sv
// self-checking bench for the execution block
module ssx_alu_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, ex = 1'b0, dst = 1'b0, wake = 1'b0;
  logic we, c, dc, z, to, pd, wclr, osc, slp;
  logic [2:0] fl;
  logic [6:0] adr = 7'h00, wa;
  logic [7:0] lit = 8'h00, fd, wd, acc, f, w;
  ssx_pkg::ssx_op_t op = ssx_pkg::SSX_OP_NONE;
  int errors = 0, comparisons = 0;
  // 200 MHz core clock
  always #2.5 clk = ~clk;
  ssx_alu dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .EXEC_I(ex), .OP_I(op), .DEST_I(dst), .FILE_ADDR_I(adr),
    .LITERAL_I(lit), .FILE_DATA_I(fd), .WAKE_I(wake), .FILE_WE_O(we), .FILE_WADDR_O(wa), .FILE_WDATA_O(wd),
    .ACC_O(acc), .CARRY_O(c), .DIGIT_CARRY_FLAG_O(dc), .ZERO_O(z), .TIMEOUT_FLAG_O(to),
    .POWERDOWN_FLAG_O(pd), .WDT_CLR_O(wclr), .OSC_RUN_O(osc), .SLEEPING_O(slp));
  ssx_file_model fm (.clk_i(clk), .we_i(we), .waddr_i(wa), .wdata_i(wd), .addr_i(adr), .data_o(fd));
  // case inequality so an unknown never matches
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one instruction; old acc, file and flags kept for expectations
  task automatic run(input ssx_pkg::ssx_op_t o, input logic d, input logic [6:0] a, input logic [7:0] k);
    @(negedge clk);
    op = o;
    dst = d;
    adr = a;
    lit = k;
    ex = 1'b1;
    // the file model bypasses a write still in flight, so the old value does too
    f = (we && wa == a) ? wd : fm.mem[a];
    w = acc;
    fl = {c, dc, z};
    @(negedge clk);
    ex = 1'b0;
  endtask : run
  task automatic t_sub;
    run(ssx_pkg::SSX_OP_XOR_LITERAL_ACC, 1'b0, 7'h00, 8'h35);
    run(ssx_pkg::SSX_OP_SUB_ACC_FROM_FILE, 1'b1, 7'h7F, 8'h00);
    chk("sub wdata", wd, f - w);
    chk("sub we acc", {we, acc[6:0]}, {1'b1, w[6:0]});
    chk("sub flags", {5'h00, c, dc, z}, {5'h00, w <= f, w[3:0] <= f[3:0], f == w});
    run(ssx_pkg::SSX_OP_SUB_ACC_FROM_LITERAL, 1'b1, 7'h00, 8'h0F);
    chk("subl acc", acc, 8'h0F - w);
    chk("subl flags", {5'h00, c, dc, z}, {5'h00, w <= 8'h0F, 1'b1, 1'b0});
    run(ssx_pkg::SSX_OP_SUB_ACC_FROM_LITERAL, 1'b0, 7'h00, acc);
    chk("subl zero", {acc[4:0], c, dc, z}, 8'h07);
    $display("test sub done");
  endtask : t_sub
  task automatic t_swap_xor;
    run(ssx_pkg::SSX_OP_NIBBLE_SWAP_FILE, 1'b1, 7'h09, 8'h00);
    chk("swap wdata", wd, {f[3:0], f[7:4]});
    chk("swap flags", {5'h00, c, dc, z}, {5'h00, fl});
    run(ssx_pkg::SSX_OP_NIBBLE_SWAP_FILE, 1'b0, 7'h09, 8'h00);
    chk("swap acc", acc, {f[3:0], f[7:4]});
    run(ssx_pkg::SSX_OP_XOR_ACC_FILE, 1'b1, 7'h40, 8'h00);
    chk("xorf wdata", wd, w ^ f);
    chk("xorf flags", {4'h0, we, c, dc, z}, {4'h1, fl[2:1], (w ^ f) == 8'h00});
    run(ssx_pkg::SSX_OP_XOR_LITERAL_ACC, 1'b1, 7'h00, acc);
    chk("xorl", {acc[3:0], we, c, dc, z}, {4'h0, 1'b0, fl[2:1], 1'b1});
    run(ssx_pkg::SSX_OP_ROTATE_RIGHT_CARRY, 1'b0, 7'h03, 8'h00);
    chk("rotate acc", acc, {fl[2], f[7:1]});
    chk("rotate carry", {7'h00, c}, {7'h00, f[0]});
    $display("test swap xor rotate done");
  endtask : t_swap_xor
  task automatic t_sleep;
    run(ssx_pkg::SSX_OP_SLEEP, 1'b0, 7'h00, 8'h00);
    chk("sleep entry", {3'h0, wclr, pd, to, osc, slp}, 8'h15);
    run(ssx_pkg::SSX_OP_XOR_LITERAL_ACC, 1'b0, 7'h00, 8'hAA);
    chk("sleep hold", {3'h0, wclr, pd, to, osc, slp}, 8'h05);
    chk("sleep refuse", acc, w);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    chk("wake", {6'h00, osc, slp}, 8'h02);
    $display("test sleep done");
  endtask : t_sleep
  // verdict and end of run
  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (6) @(negedge clk);
    chk("reset", {acc[3:0], to, pd, osc, slp}, 8'h0E);
    rst_n = 1'b1;
    t_sub();
    t_swap_xor();
    t_sleep();
    final_report();
  end
  // tests take about 29 cycles; this is far beyond
  initial begin
    #5us;
    errors++;
    final_report();
  end
endmodule : ssx_alu_tb

// >>> tb/ssx_file_model.sv
// register file model on the far side of the execution block
module ssx_file_model (
  // clock and write port
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [6:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // read port
  input wire logic [6:0] addr_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [128];
  // distinct contents so a wrong address shows
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 29);
    end
  end
  // write lands one edge late, so bypass it on read
  assign data_o = (we_i && waddr_i == addr_i) ? wdata_i : mem[addr_i];
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule : ssx_file_model
